// >>> rtl/dcfp_pkg.sv
// constants, field layouts and types shared by the dual-port fifo block
// assumes a 125 mhz system clock and an axi4-lite master with 32-bit data
package dcfp_pkg;

  // storage geometry
  localparam int DEPTH_DEFAULT = 512;
  localparam int DATA_W        = 36;

  // system clock
  localparam int CLK_SYS_MHZ = 125;

  // register map, byte addresses
  localparam int              AXI_AW     = 4;
  localparam logic [AXI_AW-1:0] REG_CTRL   = 4'h0;
  localparam logic [AXI_AW-1:0] REG_STATUS = 4'h4;
  localparam logic [AXI_AW-1:0] REG_OFFSET = 4'h8;

  // control register fields
  localparam int CTRL_PAR_ARM = 0;
  localparam int CTRL_SER_EN  = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // status register fields
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL  = 1;
  localparam int ST_IR    = 2;
  localparam int ST_OR    = 3;
  localparam int ST_AF    = 4;
  localparam int ST_AE    = 5;
  localparam int ST_MAIL1 = 6;
  localparam int ST_MAIL2 = 7;
  localparam int ST_RTM   = 8;
  localparam int ST_COUNT = 16;

  // offset register fields and preset offsets
  localparam int OFS_X_LSB     = 0;
  localparam int OFS_Y_LSB     = 16;
  localparam int AE_OFFSET_RST = 8;
  localparam int AF_OFFSET_RST = 8;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // parallel offset load sequence
  typedef enum logic [1:0] {OFS_IDLE, OFS_WAIT_X, OFS_WAIT_Y} dcfp_ofs_state_t;

endpackage

// >>> rtl/dcfp_pin_sync.sv
// three-stage input synchroniser for pins arriving from outside clk_sys
// assumes every bit is independent; a bit changes once stages two and three agree
`timescale 1ns/1ps
module dcfp_pin_sync #(
  parameter int WIDTH = 1
)(
  // system
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // pins
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1Reg;
  logic [WIDTH-1:0] stage2Reg;
  logic [WIDTH-1:0] stage3Reg;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("dcfp_pin_sync: WIDTH must be at least one");
    end
  endgenerate

  // stage one feeds stage two only, so no logic ever sees a metastable level
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage1Reg <= '0;
      stage2Reg <= '0;
      stage3Reg <= '0;
      pinOut    <= '0;
    end else begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      pinOut    <= (stage2Reg & stage3Reg) | (pinOut & (stage2Reg ^ stage3Reg));
    end
  end

endmodule

// >>> rtl/dcfp_ports.sv
// dual-port fifo of 36-bit words with mailboxes, programmable flags and retransmit
// assumes port clocks and controls arrive as pins, sampled on clk_sys; registers on axi4-lite
`timescale 1ns/1ps
module dcfp_ports
  import dcfp_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEFAULT
)(
  // system
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // port a pins
  input  wire logic              write_port_clock,
  input  wire logic              write_port_select_n,
  input  wire logic              write_port_enable,
  input  wire logic              write_port_direction,
  input  wire logic              writePortMailboxSel,
  input  wire logic              serialLoadEnable_n,
  input  wire logic              serialData,
  input  wire logic [DATA_W-1:0] write_side_data_bus_in,
  output logic      [DATA_W-1:0] write_side_data_bus_out,
  output logic                   write_side_data_bus_oe,
  // port b pins
  input  wire logic              read_port_clock,
  input  wire logic              read_port_select_n,
  input  wire logic              read_port_enable,
  input  wire logic              read_port_direction,
  input  wire logic              readPortMailboxSel,
  input  wire logic              retransmitMode,
  input  wire logic              readFromMark,
  input  wire logic [DATA_W-1:0] read_side_data_bus_in,
  output logic      [DATA_W-1:0] read_side_data_bus_out,
  output logic                   read_side_data_bus_oe,
  // flags
  output logic                   input_ready_flag,
  output logic                   almost_full_n,
  output logic                   outputReadyFlag,
  output logic                   almost_empty_n,
  output logic                   mailToReadFlag_n,
  output logic                   mailToWriteFlag_n,
  output logic                   fifoEmpty,
  output logic                   fifoFull,
  // axi4-lite slave
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  localparam int AW    = $clog2(DEPTH);
  localparam int PW    = AW + 1;
  localparam int PIN_W = 2 * DATA_W + 14;

  generate
    if (DEPTH != 512 && DEPTH != 1024 && DEPTH != 2048) begin : g_bad_depth
      $error("dcfp_ports: DEPTH must be 512, 1024 or 2048");
    end
  endgenerate

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // synchronised pin levels; clock and data share one path so they stay aligned
  logic              aClkS, aSelNS, aEnS, aDirS, aMbS, serEnNS, serDatS;
  logic              bClkS, bSelNS, bEnS, bDirS, bMbS, rtmS, rfmS;
  logic [DATA_W-1:0] aDataS, bDataS;

  dcfp_pin_sync #(
    .WIDTH (PIN_W)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .pinIn   ({write_port_clock, write_port_select_n, write_port_enable,
                write_port_direction, writePortMailboxSel, serialLoadEnable_n, serialData,
                write_side_data_bus_in,
                read_port_clock, read_port_select_n, read_port_enable, read_port_direction,
                readPortMailboxSel, retransmitMode, readFromMark, read_side_data_bus_in}),
    .pinOut  ({aClkS, aSelNS, aEnS, aDirS, aMbS, serEnNS, serDatS, aDataS,
               bClkS, bSelNS, bEnS, bDirS, bMbS, rtmS, rfmS, bDataS})
  );

  // port clock edge detection; each port keeps its own edge, so the clocks stay independent
  logic aClkPrev;
  logic bClkPrev;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aClkPrev <= 1'b0;
      bClkPrev <= 1'b0;
    end else begin
      aClkPrev <= aClkS;
      bClkPrev <= bClkS;
    end
  end

  logic aEdge, bEdge, aQual, bQual, aWrite, aRead, bWrite, bRead;
  logic fifoWrite, fifoRead, rewind;
  logic [AW-1:0]       aeOffset, afOffset;
  dcfp_ofs_state_t     ofsState;
  logic                serialAllow;
  logic                rtMode;
  logic [PW-1:0]       wrPtr, rdPtr, markPtr;

  assign aEdge  = aClkS & ~aClkPrev;
  assign bEdge  = bClkS & ~bClkPrev;
  assign aQual  = aEdge & ~aSelNS & aEnS;
  assign bQual  = bEdge & ~bSelNS & bEnS;
  assign aWrite = aQual & aDirS;
  assign aRead  = aQual & ~aDirS;
  assign bWrite = bQual & ~bDirS;
  assign bRead  = bQual & bDirS;
  // writes are held off while the flag offsets are being loaded in parallel
  assign fifoWrite = aWrite & ~aMbS & input_ready_flag & (ofsState == OFS_IDLE);
  assign rewind    = bQual & rtMode & rfmS;
  assign fifoRead  = bRead & ~bMbS & outputReadyFlag & ~rewind;

  // storage array; data only, so it carries no reset
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (fifoWrite) begin
      mem[wrPtr[AW-1:0]] <= aDataS;
    end
  end

  // write pointer and its gray copy, which changes one bit per write
  logic [PW-1:0] wrPtrNext, wrGrayReg;

  assign wrPtrNext = fifoWrite ? PW'(wrPtr + 1'b1) : wrPtr;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr     <= '0;
      wrGrayReg <= '0;
    end else begin
      wrPtr     <= wrPtrNext;
      wrGrayReg <= bin2gray(wrPtrNext);
    end
  end

  // read pointer; a read-from-mark edge itself delivers the marked word, so the
  // pointer lands just past the mark and the next read does not repeat it
  logic [PW-1:0] rdPtrNext, rdEff, rdEffGray;

  assign rdPtrNext = rewind ? PW'(markPtr + 1'b1) : (fifoRead ? PW'(rdPtr + 1'b1) : rdPtr);
  // while retransmitting, the write side sees the mark so marked data is not overwritten
  assign rdEff = rtMode ? markPtr : rdPtrNext;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdPtr     <= '0;
      rdEffGray <= '0;
    end else begin
      rdPtr     <= rdPtrNext;
      rdEffGray <= bin2gray(rdEff);
    end
  end

  // retransmit mode: entered on rtm high with ready data, left on any edge with rtm low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rtMode  <= 1'b0;
      markPtr <= '0;
    end else if (bEdge) begin
      if (!rtmS) begin
        rtMode <= 1'b0;
      end else if (!rtMode && outputReadyFlag) begin
        rtMode  <= 1'b1;
        markPtr <= rdPtr;
      end
    end
  end

  // two-stage pointer synchronisers between the two sides
  logic [PW-1:0] rdGrayS1, rdGrayS2, wrGrayS1, wrGrayS2;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdGrayS1 <= '0;
      rdGrayS2 <= '0;
      wrGrayS1 <= '0;
      wrGrayS2 <= '0;
    end else begin
      rdGrayS1 <= rdEffGray;
      rdGrayS2 <= rdGrayS1;
      wrGrayS1 <= wrGrayReg;
      wrGrayS2 <= wrGrayS1;
    end
  end

  // fill levels seen by each side, from next pointers so a flag is never a write late
  logic [PW-1:0] usedW, freeW, usedR;

  assign usedW = PW'(wrPtrNext - gray2bin(rdGrayS2));
  assign freeW = PW'(PW'(DEPTH) - usedW);
  assign usedR = PW'(gray2bin(wrGrayS2) - rdPtrNext);

  // write-side flags; input ready reads low during reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      input_ready_flag <= 1'b0;
      almost_full_n    <= 1'b1;
      fifoFull         <= 1'b0;
    end else begin
      input_ready_flag <= (freeW != '0);
      almost_full_n    <= !(freeW <= {1'b0, afOffset});
      fifoFull         <= (freeW == '0);
    end
  end

  // read-side flags
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      outputReadyFlag <= 1'b0;
      almost_empty_n  <= 1'b0;
      fifoEmpty       <= 1'b1;
    end else begin
      outputReadyFlag <= (usedR != '0);
      almost_empty_n  <= !(usedR <= {1'b0, aeOffset});
      fifoEmpty       <= (usedR == '0);
    end
  end

  // mailboxes; a write in the same edge as the read of the same box leaves mail pending
  logic [DATA_W-1:0] mail1Reg, mail2Reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mail1Reg          <= '0;
      mail2Reg          <= '0;
      mailToReadFlag_n  <= 1'b1;
      mailToWriteFlag_n <= 1'b1;
    end else begin
      if (aWrite && aMbS) begin
        mail1Reg         <= aDataS;
        mailToReadFlag_n <= 1'b0;
      end else if (bRead && bMbS) begin
        mailToReadFlag_n <= 1'b1;
      end
      if (bWrite && bMbS) begin
        mail2Reg          <= bDataS;
        mailToWriteFlag_n <= 1'b0;
      end else if (aRead && aMbS) begin
        mailToWriteFlag_n <= 1'b1;
      end
    end
  end

  // data outputs and drive enables; enables follow select and direction levels
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      write_side_data_bus_out <= '0;
      write_side_data_bus_oe  <= 1'b0;
      read_side_data_bus_out  <= '0;
      read_side_data_bus_oe   <= 1'b0;
    end else begin
      write_side_data_bus_oe <= ~aSelNS & ~aDirS;
      read_side_data_bus_oe  <= ~bSelNS & bDirS;
      if (aRead && aMbS) begin
        write_side_data_bus_out <= mail2Reg;
      end
      if (bRead && bMbS) begin
        read_side_data_bus_out <= mail1Reg;
      end else if (fifoRead || rewind) begin
        read_side_data_bus_out <= mem[rdPtrNext[AW-1:0] - AW'(1)];
      end
    end
  end

  // axi write channel: address and data taken in either order, then one response
  logic [AXI_AW-1:0] awAddrReg;
  logic [31:0]       wDataReg;
  logic [3:0]        wStrbReg;
  logic              awHeld, wHeld, regWrite;

  assign regWrite = awHeld & wHeld & ~s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddrReg     <= '0;
      wDataReg      <= '0;
      wStrbReg      <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awHeld        <= 1'b1;
        awAddrReg     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wHeld        <= 1'b1;
        wDataReg     <= s_axi_wdata;
        wStrbReg     <= s_axi_wstrb;
      end
      if (regWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // status and offset read back only; writes there are refused
        s_axi_bresp  <= (awAddrReg == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // serial-load permission from the control register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      serialAllow <= CTRL_RST[CTRL_SER_EN];
    end else if (regWrite && awAddrReg == REG_CTRL && wStrbReg[0]) begin
      serialAllow <= wDataReg[CTRL_SER_EN];
    end
  end

  // flag offsets: two port a words (x then y) once armed, or serial bits y msb first
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ofsState <= OFS_IDLE;
      aeOffset <= AW'(AE_OFFSET_RST);
      afOffset <= AW'(AF_OFFSET_RST);
    end else begin
      case (ofsState)
        OFS_IDLE: begin
          if (regWrite && awAddrReg == REG_CTRL && wStrbReg[0] && wDataReg[CTRL_PAR_ARM]) begin
            ofsState <= OFS_WAIT_X;
          end else if (aEdge && !serEnNS && serialAllow) begin
            {afOffset, aeOffset} <= {afOffset[AW-2:0], aeOffset, serDatS};
          end
        end
        OFS_WAIT_X: begin
          if (aWrite && !aMbS) begin
            aeOffset <= aDataS[AW-1:0];
            ofsState <= OFS_WAIT_Y;
          end
        end
        OFS_WAIT_Y: begin
          if (aWrite && !aMbS) begin
            afOffset <= aDataS[AW-1:0];
            ofsState <= OFS_IDLE;
          end
        end
        default: begin
          ofsState <= OFS_IDLE;
        end
      endcase
    end
  end

  // axi read channel: answer one cycle after the address is taken
  logic [31:0] statusWord;

  always_comb begin
    statusWord                   = '0;
    statusWord[ST_EMPTY]         = fifoEmpty;
    statusWord[ST_FULL]          = fifoFull;
    statusWord[ST_IR]            = input_ready_flag;
    statusWord[ST_OR]            = outputReadyFlag;
    statusWord[ST_AF]            = ~almost_full_n;
    statusWord[ST_AE]            = ~almost_empty_n;
    statusWord[ST_MAIL1]         = ~mailToReadFlag_n;
    statusWord[ST_MAIL2]         = ~mailToWriteFlag_n;
    statusWord[ST_RTM]           = rtMode;
    statusWord[ST_COUNT +: PW]   = usedR;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= '0;
      case (s_axi_araddr)
        REG_CTRL: begin
          s_axi_rdata[CTRL_PAR_ARM] <= (ofsState != OFS_IDLE);
          s_axi_rdata[CTRL_SER_EN]  <= serialAllow;
        end
        REG_STATUS: begin
          s_axi_rdata <= statusWord;
        end
        REG_OFFSET: begin
          s_axi_rdata[OFS_X_LSB +: AW] <= aeOffset;
          s_axi_rdata[OFS_Y_LSB +: AW] <= afOffset;
        end
        default: begin
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks on the port gating, flags and pointer crossings
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_mail1Write;
    aWrite && aMbS;
  endsequence

  sequence s_rdGrayMove;
    rdEffGray != rdGrayS1;
  endsequence

  a_full_blocks_write: assert property ((aWrite && !input_ready_flag) |=> wrPtr == $past(wrPtr))
    else $error("write taken while input ready low");
  a_empty_blocks_read: assert property ((bRead && !bMbS && !outputReadyFlag && !rewind)
    |=> rdPtr == $past(rdPtr))
    else $error("read taken while output ready low");
  a_sel_gates_a: assert property ((aEdge && aSelNS) |=> $stable(wrPtr) && $stable(mail1Reg))
    else $error("port a acted with select high");
  a_sel_gates_b: assert property ((bEdge && bSelNS) |=> $stable(rdPtr) && $stable(mail2Reg))
    else $error("port b acted with select high");
  a_en_gates_a: assert property ((aEdge && !aEnS) |=> $stable(wrPtr) && $stable(mail1Reg))
    else $error("port a acted with enable low");
  a_en_gates_b: assert property ((bEdge && !bEnS) |=> $stable(rdPtr) && $stable(mail2Reg))
    else $error("port b acted with enable low");
  a_read_advances: assert property (fifoRead |=> rdPtr == PW'($past(rdPtr) + 1'b1))
    else $error("fifo read did not advance by one");
  a_gray_one_bit: assert property ($changed(wrGrayReg) |-> $onehot(wrGrayReg ^ $past(wrGrayReg)))
    else $error("write gray pointer moved more than one bit");
  a_rd_sync_two: assert property (s_rdGrayMove |-> ##2 rdGrayS2 == $past(rdEffGray, 2))
    else $error("read pointer sync not two stages");
  a_ae_when_empty: assert property (fifoEmpty |-> !almost_empty_n)
    else $error("almost empty not asserted while empty");
  a_af_when_full: assert property (fifoFull |-> !almost_full_n)
    else $error("almost full not asserted while full");
  a_mail1_pending: assert property (s_mail1Write |=> !mailToReadFlag_n)
    else $error("mail flag not set after mailbox write");
  a_oe_off_sel: assert property (aSelNS |=> !write_side_data_bus_oe)
    else $error("port a drives bus with select high");

endmodule

// >>> bench/dcfp_port_model.sv
// far-side port controller: one pin access per start strobe
// assumes the dut samples the pins on clk_sys, at least six cycles per clock phase
`timescale 1ns/1ps
module dcfp_port_model (
  // system
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // request {mailbox, select_n, enable, direction}
  input  wire logic        start,
  input  wire logic [3:0]  ctl,
  input  wire logic [35:0] wData,
  // pins
  output logic             pinClk,
  output logic      [3:0]  pinCtl,
  output logic      [35:0] pinData,
  output logic             busy
);
  logic [4:0] cnt;
  // six cycles high, six or more low
  assign pinClk = (cnt <= 5'h12) && (cnt > 5'h0c);
  assign busy   = cnt != 5'h00;
  // controls steady six cycles before the rise and long after
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 5'h00;
      pinCtl <= 4'h4;
    end else if (start) begin
      cnt <= 5'h18;
      pinCtl <= ctl;
    end else if (busy) begin
      cnt <= cnt - 5'h01;
      if (cnt == 5'h01) pinCtl <= 4'h4;
    end
  end
  // a released bus toggles so no stale word can pass for read data
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) pinData <= 36'h0;
    else if (start) pinData <= wData;
    else if (cnt < 5'h02) pinData <= ~pinData;
  end
endmodule

// >>> bench/tb_top.sv
// fifo bench: pin accesses through two port models, registers over axi4-lite
// assumes the dut holds 512 words and both offsets reset to 8
`timescale 1ns/1ps
module tb_top;
  import dcfp_pkg::*;
  localparam int D = 512;
  logic clk_sys = 0, arst_n = 0, sA = 0, sB = 0, kA, kB, bzA, bzB, retransmitMode = 0;
  logic readFromMark = 0, serialLoadEnable_n = 1, serialData = 0;
  logic [3:0] cA = 4'h4, cB = 4'h4, pA, pB, s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic [35:0] dA = 0, mAo, mBo, last, write_side_data_bus_in, read_side_data_bus_in;
  logic [35:0] write_side_data_bus_out, read_side_data_bus_out, q[$];
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, write_side_data_bus_oe, read_side_data_bus_oe, input_ready_flag;
  logic almost_full_n, outputReadyFlag, almost_empty_n, mailToReadFlag_n, mailToWriteFlag_n;
  logic fifoEmpty, fifoFull;
  logic [8:0] xo, yo;
  int errors = 0, totalChecks = 0, seed = 82474, n, i;
  // wire level of each data bus from both drivers
  assign write_side_data_bus_in = write_side_data_bus_oe ? write_side_data_bus_out : mAo;
  assign read_side_data_bus_in = read_side_data_bus_oe ? read_side_data_bus_out : mBo;
  dcfp_port_model mA (.clk_sys(clk_sys), .arst_n(arst_n), .start(sA), .ctl(cA), .wData(dA),
    .pinClk(kA), .pinCtl(pA), .pinData(mAo), .busy(bzA));
  dcfp_port_model mB (.clk_sys(clk_sys), .arst_n(arst_n), .start(sB), .ctl(cB), .wData(dA),
    .pinClk(kB), .pinCtl(pB), .pinData(mBo), .busy(bzB));
  dcfp_ports #(.DEPTH(D)) dut (.*, .write_port_clock(kA), .write_port_select_n(pA[2]),
    .write_port_enable(pA[1]), .write_port_direction(pA[0]), .writePortMailboxSel(pA[3]),
    .read_port_clock(kB), .read_port_select_n(pB[2]), .read_port_enable(pB[1]),
    .read_port_direction(pB[0]), .readPortMailboxSel(pB[3]));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic aeExp(int c);
    return c > xo;
  endfunction
  function automatic logic afExp(int c);
    return (D - c) > yo;
  endfunction
  task automatic close_out();
    if (errors == 0 && totalChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] s, input logic [35:0] e);
    totalChecks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one pin access on port a (b=0) or b, waiting until the model lets go
  task automatic acc(input bit b, input logic [3:0] c);
    dA <= 36'({$random(seed), $random(seed)});
    if (b) cB <= c;
    else cA <= c;
    sA <= !b;
    sB <= b;
    @(posedge clk_sys);
    sA <= 0;
    sB <= 0;
    for (i = 0; i < 40 && (i < 2 || bzA || bzB); i++) @(posedge clk_sys);
    if (i == 40) begin errors++; close_out(); end
  endtask
  // address and data offered together, each dropped once taken
  task automatic axi(input bit w, input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_bvalid && w) begin rs = s_axi_bresp; s_axi_bready <= 0; break; end
      if (s_axi_rvalid && !w) begin rs = s_axi_rresp; rd = s_axi_rdata; s_axi_rready <= 0; break; end
    end
    if (i == 50) begin errors++; close_out(); end
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    chk("fifoEmpty", fifoEmpty, 1);
    arst_n <= 1;
    repeat (6) @(posedge clk_sys);
    axi(0, REG_OFFSET, 0);
    chk("offsets", rd, 32'h0008_0008);
    axi(1, REG_STATUS, 32'hffff);
    chk("roWrite", rs, RESP_SLVERR);
    axi(0, 4'hc, 0);
    chk("unmapped", rs, RESP_SLVERR);
    // parallel offset load: two port a words, x then y, kept out of the fifo
    axi(1, REG_CTRL, 32'h1);
    acc(0, 4'b0011);
    xo = dA[8:0];
    acc(0, 4'b0011);
    yo = dA[8:0];
    axi(0, REG_OFFSET, 0);
    chk("parLoad", rd, {7'h0, yo, 7'h0, xo});
    chk("parHeld", fifoEmpty, 1);
    // serial offset load: random bits, y msb first, one per port a clock rise
    axi(1, REG_CTRL, 32'h2);
    serialLoadEnable_n <= 0;
    for (n = 0; n < 18; n++) begin
      serialData <= 1'($random(seed));
      acc(0, 4'b0111);
      {yo, xo} = {yo[7:0], xo, serialData};
    end
    serialLoadEnable_n <= 1;
    axi(0, REG_OFFSET, 0);
    chk("serLoad", rd, {7'h0, yo, 7'h0, xo});
    acc(0, 4'b0111);
    acc(0, 4'b0001);
    chk("unqualified", fifoEmpty, 1);
    acc(0, 4'b1011);
    last = dA;
    chk("mailFlag", mailToReadFlag_n, 0);
    acc(1, 4'b1011);
    chk("mailData", read_side_data_bus_out, last);
    repeat (8) @(posedge clk_sys);
    chk("idleOe", read_side_data_bus_oe, 0);
    // mail2: port b writes, port a reads it back while driving its bus
    acc(1, 4'b1010);
    last = dA;
    chk("mail2Flag", mailToWriteFlag_n, 0);
    acc(0, 4'b1010);
    chk("aOe", write_side_data_bus_oe, 1);
    chk("mail2Data", write_side_data_bus_out, last);
    chk("mail2Clear", mailToWriteFlag_n, 1);
    // fill one past full; the extra word must be dropped
    for (n = 0; n <= D; n++) begin
      acc(0, 4'b0011);
      if (n < D) q.push_back(dA);
      chk("almostEmpty", almost_empty_n, aeExp(q.size()));
      chk("almostFull", almost_full_n, afExp(q.size()));
    end
    chk("inputReady", input_ready_flag, 0);
    acc(1, 4'b0111);
    acc(1, 4'b0001);
    chk("fifoFull", fifoFull, 1);
    axi(0, REG_STATUS, 0);
    chk("status", {rd[ST_COUNT +: 10], rd[3:0]}, {10'(D), 4'ha});
    for (n = 0; n < D; n++) begin
      acc(1, 4'b0011);
      last = q.pop_front();
      chk("readWord", read_side_data_bus_out, last);
    end
    acc(1, 4'b0011);
    chk("emptyRead", read_side_data_bus_out, last);
    chk("outputReady", outputReadyFlag, 0);
    // retransmit: mark the first of three words, read two, rewind, read on
    for (n = 0; n < 3; n++) begin
      acc(0, 4'b0011);
      q.push_back(dA);
    end
    retransmitMode <= 1;
    acc(1, 4'b0111);
    for (n = 0; n < 5; n++) begin
      readFromMark <= (n == 2);
      acc(1, 4'b0011);
      chk("retransmit", read_side_data_bus_out, q[n < 2 ? n : n - 2]);
    end
    close_out();
  end
endmodule
